// file: rtl/chm_pkg.sv
// Overview of operation
// - words zero and one hold counters only
// - producer bumps its counter after payload
// - consumer echoes producer counter as acknowledge
// - plc writes command payload, then counter
// - device echoes command counter into response
// - device writes response, then bumps counter
// - plc echoes response counter into command
// - device zeroes response payload after plc acknowledge
// - device polls and refreshes on timers
// - command buffer inbound, response buffer outbound
package chm_pkg;
   // ************************************************************
   // buffer layout
   // ************************************************************
   localparam int unsigned WORD_W    = 16;
   localparam int unsigned DEPTH     = 16;
   localparam int unsigned ADDR_W    = 4;
   localparam int unsigned PAY_WORDS = 4;
   localparam logic [3:0]  W_ACK     = 4'h0;
   localparam logic [3:0]  W_CNT     = 4'h1;
   localparam logic [3:0]  W_PAY     = 4'h2;
   localparam logic        SEL_CMD   = 1'b0;
   localparam logic        SEL_RSP   = 1'b1;
   localparam logic [15:0] WORD_RST  = 16'h0000;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned POLL_RATE_MS  = 10;
   localparam int unsigned HB_TIMEOUT_MS = 100;
   localparam int unsigned POLL_CYC      = POLL_RATE_MS * (CLK_HZ / 1000);
   localparam int unsigned HB_CYC        = HB_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned TMR_W         = 24;

   typedef logic [PAY_WORDS-1:0][WORD_W-1:0] chm_pay_t;
endpackage

// file: rtl/chm_if.sv
`timescale 1ns/1ps
interface chm_if;
   logic                      req;
   logic                      we;
   logic                      sel;
   logic [chm_pkg::ADDR_W-1:0] addr;
   logic [chm_pkg::WORD_W-1:0] wdata;
   logic                      ack;
   logic [chm_pkg::WORD_W-1:0] rdata;

   modport device (output req, output we, output sel, output addr, output wdata, input ack, input rdata);
   modport plc    (input req, input we, input sel, input addr, input wdata, output ack, output rdata);
endinterface

// file: rtl/chm_device.sv
`timescale 1ns/1ps
module chm_device #(
   parameter int unsigned POLL_CYC_P = chm_pkg::POLL_CYC,
   parameter int unsigned HB_CYC_P   = chm_pkg::HB_CYC
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // link to plc memory
   chm_if.device                 lnk,
   // command out to the antenna logic
   output logic                  cmd_valid,
   output chm_pkg::chm_pay_t     cmd_data,
   // response in from the antenna logic
   input  wire logic             rsp_valid,
   input  wire chm_pkg::chm_pay_t rsp_data,
   output logic                  rsp_ready,
   // status
   output logic                  busy
);
   import chm_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef enum logic [3:0] {
      D_IDLE  = 4'h0,
      D_RDCNT = 4'h1,
      D_WRACK = 4'h2,
      D_RDPAY = 4'h3,
      D_EXEC  = 4'h4,
      D_WRPAY = 4'h5,
      D_WRCNT = 4'h6,
      D_RDPAK = 4'h7,
      D_WTPAK = 4'h8,
      D_CLR   = 4'h9,
      D_HB    = 4'ha
   } chm_dst_t;

   typedef struct packed {
      chm_dst_t          st;
      logic              pend;
      logic              req;
      logic              we;
      logic              sel;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
      logic [1:0]        idx;
      logic [WORD_W-1:0] last_cnt;
      logic [WORD_W-1:0] rsp_cnt;
      chm_pay_t          pay;
      logic [TMR_W-1:0]  poll_tmr;
      logic [TMR_W-1:0]  hb_tmr;
      logic              cmd_valid;
   } chm_dev_t;

   localparam logic [TMR_W-1:0] POLL_LD = TMR_W'(POLL_CYC_P - 1);
   localparam logic [TMR_W-1:0] HB_LD   = TMR_W'(HB_CYC_P - 1);

   chm_dev_t s_reg;
   chm_dev_t s_next;
   logic     done;

   // one access at a time; done marks its answer
   assign done = s_reg.pend & lnk.ack;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      s_next     = s_reg;
      s_next.req = 1'b0;
      if (done)
      begin
         s_next.pend = 1'b0;
      end
      if (s_reg.poll_tmr != '0)
      begin
         s_next.poll_tmr = s_reg.poll_tmr - 1'b1;
      end
      if (s_reg.hb_tmr != '0)
      begin
         s_next.hb_tmr = s_reg.hb_tmr - 1'b1;
      end
      unique case (s_reg.st)
         D_IDLE:
         begin
            if (s_reg.hb_tmr == '0)
            begin
               // refresh the acknowledge word so the plc sees a live link
               s_next.st = D_HB;
            end
            else if (s_reg.poll_tmr == '0)
            begin
               s_next.st = D_RDCNT;
            end
         end
         D_HB:
         begin
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b1, SEL_RSP, W_ACK, s_reg.last_cnt);
            end
            else if (done)
            begin
               s_next.hb_tmr = HB_LD;
               s_next.st     = D_IDLE;
            end
         end
         D_RDCNT:
         begin
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b0, SEL_CMD, W_CNT, WORD_RST);
            end
            else if (done)
            begin
               s_next.poll_tmr = POLL_LD;
               if (lnk.rdata != s_reg.last_cnt)
               begin
                  s_next.last_cnt = lnk.rdata;
                  s_next.st       = D_WRACK;
               end
               else
               begin
                  s_next.st = D_IDLE;
               end
            end
         end
         D_WRACK:
         begin
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b1, SEL_RSP, W_ACK, s_reg.last_cnt);
            end
            else if (done)
            begin
               s_next.hb_tmr = HB_LD;
               s_next.idx    = 2'h0;
               s_next.st     = D_RDPAY;
            end
         end
         D_RDPAY:
         begin
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b0, SEL_CMD, W_PAY + ADDR_W'(s_reg.idx), WORD_RST);
            end
            else if (done)
            begin
               s_next.pay[s_reg.idx] = lnk.rdata;
               s_next.idx            = s_reg.idx + 1'b1;
               if (s_reg.idx == 2'(PAY_WORDS - 1))
               begin
                  s_next.cmd_valid = 1'b1;
                  s_next.st        = D_EXEC;
               end
            end
         end
         D_EXEC:
         begin
            if (rsp_valid)
            begin
               s_next.pay       = rsp_data;
               s_next.cmd_valid = 1'b0;
               s_next.idx       = 2'h0;
               s_next.st        = D_WRPAY;
            end
         end
         D_WRPAY:
         begin
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b1, SEL_RSP, W_PAY + ADDR_W'(s_reg.idx), s_reg.pay[s_reg.idx]);
            end
            else if (done)
            begin
               s_next.idx = s_reg.idx + 1'b1;
               if (s_reg.idx == 2'(PAY_WORDS - 1))
               begin
                  s_next.st = D_WRCNT;
               end
            end
         end
         D_WRCNT:
         begin
            // counter goes last so the plc never sees a half written response
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b1, SEL_RSP, W_CNT, s_reg.rsp_cnt + 1'b1);
            end
            else if (done)
            begin
               s_next.rsp_cnt = s_reg.rsp_cnt + 1'b1;
               s_next.st      = D_RDPAK;
            end
         end
         D_RDPAK:
         begin
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b0, SEL_CMD, W_ACK, WORD_RST);
            end
            else if (done)
            begin
               s_next.poll_tmr = POLL_LD;
               s_next.idx      = 2'h0;
               s_next.st       = (lnk.rdata == s_reg.rsp_cnt) ? D_CLR : D_WTPAK;
            end
         end
         D_WTPAK:
         begin
            if (s_reg.poll_tmr == '0)
            begin
               s_next.st = D_RDPAK;
            end
         end
         D_CLR:
         begin
            // counters stay; only the payload words are zeroed
            if (!s_reg.pend)
            begin
               s_next = issue(s_next, 1'b1, SEL_RSP, W_PAY + ADDR_W'(s_reg.idx), WORD_RST);
            end
            else if (done)
            begin
               s_next.idx = s_reg.idx + 1'b1;
               if (s_reg.idx == 2'(PAY_WORDS - 1))
               begin
                  s_next.st = D_IDLE;
               end
            end
         end
         default:
         begin
            s_next.st = D_IDLE;
         end
      endcase
   end

   function automatic chm_dev_t issue(input chm_dev_t s, input logic we, input logic sel,
                                      input logic [ADDR_W-1:0] addr, input logic [WORD_W-1:0] wd);
      chm_dev_t r;
      r       = s;
      r.req   = 1'b1;
      r.pend  = 1'b1;
      r.we    = we;
      r.sel   = sel;
      r.addr  = addr;
      r.wdata = wd;
      return r;
   endfunction

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign lnk.req   = s_reg.req;
   assign lnk.we    = s_reg.we;
   assign lnk.sel   = s_reg.sel;
   assign lnk.addr  = s_reg.addr;
   assign lnk.wdata = s_reg.wdata;
   assign cmd_valid = s_reg.cmd_valid;
   assign cmd_data  = s_reg.pay;
   assign rsp_ready = (s_reg.st == D_EXEC);
   assign busy      = (s_reg.st != D_IDLE);
endmodule // chm_device

// file: rtl/chm_plc.sv
`timescale 1ns/1ps
module chm_plc (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   // link from the device
   chm_if.plc                     lnk,
   // command in from plc program
   input  wire logic              cmd_go,
   input  wire chm_pkg::chm_pay_t cmd_pay,
   output logic                   cmd_ready,
   // response out to plc program
   output logic                   rsp_valid,
   output chm_pkg::chm_pay_t      rsp_pay,
   input  wire logic              rsp_ack
);
   import chm_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef enum logic [0:0] {
      P_IDLE = 1'b0,
      P_INC  = 1'b1
   } chm_pst_t;

   typedef struct packed {
      chm_pst_t                       st;
      logic [DEPTH-1:0][WORD_W-1:0]   cmd_mem;
      logic [DEPTH-1:0][WORD_W-1:0]   rsp_mem;
      logic                           ack;
      logic [WORD_W-1:0]              rdata;
   } chm_plc_t;

   chm_plc_t s_reg;
   chm_plc_t s_next;

   always_comb
   begin
      s_next       = s_reg;
      s_next.ack   = lnk.req;
      s_next.rdata = (lnk.sel == SEL_RSP) ? s_reg.rsp_mem[lnk.addr] : s_reg.cmd_mem[lnk.addr];
      // device owns the response buffer; its writes to the command buffer are dropped
      if (lnk.req && lnk.we && (lnk.sel == SEL_RSP))
      begin
         s_next.rsp_mem[lnk.addr] = lnk.wdata;
      end
      unique case (s_reg.st)
         P_IDLE:
         begin
            if (cmd_go)
            begin
               for (int i = 0; i < PAY_WORDS; i++)
               begin
                  s_next.cmd_mem[int'(W_PAY) + i] = cmd_pay[i];
               end
               s_next.st = P_INC;
            end
         end
         P_INC:
         begin
            s_next.cmd_mem[W_CNT] = s_reg.cmd_mem[W_CNT] + 1'b1;
            s_next.st             = P_IDLE;
         end
      endcase
      if (rsp_ack)
      begin
         s_next.cmd_mem[W_ACK] = s_reg.rsp_mem[W_CNT];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign lnk.ack   = s_reg.ack;
   assign lnk.rdata = s_reg.rdata;
   assign cmd_ready = (s_reg.st == P_IDLE);
   // a fresh response is a response counter not yet echoed
   assign rsp_valid = (s_reg.rsp_mem[W_CNT] != s_reg.cmd_mem[W_ACK]);
   always_comb
   begin
      for (int i = 0; i < PAY_WORDS; i++)
      begin
         rsp_pay[i] = s_reg.rsp_mem[int'(W_PAY) + i];
      end
   end
endmodule // chm_plc

// file: bench/chm_link_monitor.sv
`timescale 1ns/1ps
// ********
// link checker
// ********
module chm_link_monitor (
   // clock and reset
   input wire logic                       clk_sys,
   input wire logic                       rstn,
   // link signals
   input wire logic                       req,
   input wire logic                       we,
   input wire logic                       sel,
   input wire logic [chm_pkg::ADDR_W-1:0] addr,
   input wire logic [chm_pkg::WORD_W-1:0] wdata,
   input wire logic                       ack,
   input wire logic [chm_pkg::WORD_W-1:0] rdata
);
   import chm_pkg::*;
   typedef struct packed {
      logic        rd1;
      logic [3:0]  wa;
      logic [15:0] seen;
      logic [15:0] rcnt;
   } chm_mon_t;
   chm_mon_t mon_reg;
   chm_mon_t mon_next;

   // shadows of the command counter the device last read and of its last response write address and counter
   always_comb
   begin
      mon_next = mon_reg;
      if (req)
         mon_next.rd1 = !we && !sel && addr == W_CNT;
      if (ack && mon_reg.rd1)
         mon_next.seen = rdata;
      if (req && we && sel)
         mon_next.wa = addr;
      if (req && we && sel && addr == W_CNT)
         mon_next.rcnt = wdata;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         mon_reg <= '0;
      else
         mon_reg <= mon_next;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_rsp_wr(logic [3:0] a);
      req && we && sel && addr == a;
   endsequence

   chk_ack_follows: assert property (req |=> ack ##1 !ack)
      else $error("ack missing after req");
   chk_ack_cause: assert property (ack |-> $past(req))
      else $error("ack without req");
   chk_req_gap: assert property (req |=> !req [*2])
      else $error("req spacing too short");
   chk_wr_rsp_only: assert property (req && we |-> sel)
      else $error("device wrote command buffer");
   chk_ack_echo: assert property (s_rsp_wr(W_ACK) |-> wdata == mon_reg.seen)
      else $error("ack word not last command count");
   chk_pay_first: assert property (s_rsp_wr(W_CNT) |-> mon_reg.wa == W_PAY + 3)
      else $error("counter written before payload");
   chk_cnt_step: assert property (s_rsp_wr(W_CNT) |-> wdata == mon_reg.rcnt + 16'h0001)
      else $error("response count not plus one");
   chk_addr_span: assert property (req |-> addr < W_PAY + PAY_WORDS)
      else $error("access outside counters and payload");
endmodule // chm_link_monitor

// file: bench/counter_handshake_mailbox_bench.sv
`timescale 1ns/1ps
module counter_handshake_mailbox_bench;
   import chm_pkg::*;
   logic     clk_sys;
   logic     rstn;
   logic     dev_cmd_valid;
   chm_pay_t dev_cmd_data;
   logic     dev_rsp_valid;
   chm_pay_t dev_rsp_data;
   logic     dev_rsp_ready;
   logic     dev_busy;
   logic     plc_cmd_go;
   chm_pay_t plc_cmd_pay;
   logic     plc_cmd_ready;
   logic     plc_rsp_valid;
   chm_pay_t plc_rsp_pay;
   logic     plc_rsp_ack;
   int       num_errors;
   int       n_compared;

   chm_if lnk ();
   // short timers keep the run brief
   chm_device #(.POLL_CYC_P(20), .HB_CYC_P(200)) chm_device_i (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk),
      .cmd_valid(dev_cmd_valid), .cmd_data(dev_cmd_data), .rsp_valid(dev_rsp_valid),
      .rsp_data(dev_rsp_data), .rsp_ready(dev_rsp_ready), .busy(dev_busy));
   chm_plc chm_plc_i (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk), .cmd_go(plc_cmd_go),
      .cmd_pay(plc_cmd_pay), .cmd_ready(plc_cmd_ready), .rsp_valid(plc_rsp_valid),
      .rsp_pay(plc_rsp_pay), .rsp_ack(plc_rsp_ack));
   chm_link_monitor chm_link_monitor_i (.clk_sys(clk_sys), .rstn(rstn), .req(lnk.req), .we(lnk.we),
      .sel(lnk.sel), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // a wait that used up its bound ends the run
   task automatic lim(input int i);
      if (i >= 400)
      begin
         num_errors++;
         tally_and_finish;
      end
   endtask

   // ********
   // scenarios
   // ********
   task automatic scen_exchange(input chm_pay_t p, input chm_pay_t r, input int late);
      int i;
      chk({63'h0, plc_cmd_ready}, 64'h1);
      plc_cmd_pay = p;
      plc_cmd_go = 1'b1;
      tick;
      plc_cmd_go = 1'b0;
      chk({63'h0, plc_cmd_ready}, 64'h0);
      for (i = 0; i < 400 && dev_cmd_valid !== 1'b1; i++) tick;
      lim(i);
      chk(dev_cmd_data, p);
      chk({63'h0, dev_rsp_ready}, 64'h1);
      dev_rsp_data = r;
      dev_rsp_valid = 1'b1;
      tick;
      dev_rsp_valid = 1'b0;
      dev_rsp_data = ~r;
      chk({63'h0, dev_rsp_ready}, 64'h0);
      for (i = 0; i < 400 && plc_rsp_valid !== 1'b1; i++) tick;
      lim(i);
      chk(plc_rsp_pay, r);
      repeat (late) tick;
      chk({63'h0, dev_busy}, 64'h1);
      // the response must survive until the plc has echoed its counter
      chk(plc_rsp_pay, r);
      plc_rsp_ack = 1'b1;
      tick;
      plc_rsp_ack = 1'b0;
      for (i = 0; i < 400 && dev_busy !== 1'b0; i++) tick;
      lim(i);
      chk(plc_rsp_pay, 64'h0);
      chk({63'h0, plc_rsp_valid}, 64'h0);
   endtask

   // with the counter unchanged, polls and heartbeats go on but raise no command
   task automatic scen_no_repeat;
      int   i;
      int   polls;
      int   hbs;
      logic seen;
      seen  = 1'b0;
      polls = 0;
      hbs   = 0;
      for (i = 0; i < 250; i++)
      begin
         tick;
         if (dev_cmd_valid !== 1'b0)
            seen = 1'b1;
         if (lnk.req === 1'b1 && lnk.we === 1'b0 && lnk.sel === SEL_CMD && lnk.addr === W_CNT)
            polls++;
         if (lnk.req === 1'b1 && lnk.we === 1'b1 && lnk.sel === SEL_RSP && lnk.addr === W_ACK)
            hbs++;
      end
      chk({63'h0, seen}, 64'h0);
      // poll period is about 23 cycles with the short timer, heartbeat about 200
      chk({63'h0, polls >= 9}, 64'h1);
      chk({63'h0, hbs >= 1}, 64'h1);
   endtask

   initial
   begin
      rstn = 1'b0;
      plc_cmd_go = 1'b0;
      plc_cmd_pay = '0;
      plc_rsp_ack = 1'b0;
      dev_rsp_valid = 1'b0;
      dev_rsp_data = '0;
      num_errors = 0;
      n_compared = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      scen_exchange(64'h07d0_0001_aa07_0006, 64'h0204_0601_aa07_000a, 0);
      scen_no_repeat;
      scen_exchange(64'hf0f0_000f_0100_e004, 64'h3408_0009_ffff_8001, 45);
      scen_exchange(64'h0000_0000_0000_0000, 64'hffff_ffff_ffff_ffff, 0);
      scen_no_repeat;
      tally_and_finish;
   end
endmodule // counter_handshake_mailbox_bench
